// ===== hdl/supply_integrity_pkg.sv
// Shared constants and types for the supply integrity monitor.
// Assumes a single CPU clock domain and an 8-bit control/status register.
package supply_integrity_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] CSR_OFFSET = 4'h0;

  // ------------------------------------------------------------
  // Control/status field positions
  // ------------------------------------------------------------
  localparam int BIT_WATCHDOG = 0;
  localparam int BIT_BROWNOUT = 4;
  localparam int BIT_WARN = 5;
  localparam int BIT_IRQ_EN = 6;
  localparam logic [DATA_W-1:0] CSR_RESET = 8'h00;

  // ------------------------------------------------------------
  // Post-reset delay, in CPU cycles
  // ------------------------------------------------------------
  localparam int SHORT_DELAY_CYC = 256;
  localparam int LONG_DELAY_CYC = 4096;
  localparam int DELAY_CNT_W = 13;

  // ------------------------------------------------------------
  // CPU interrupt mask: level 3 blocks maskable interrupts
  // ------------------------------------------------------------
  localparam logic [1:0] LEVEL_MASKED = 2'h3;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    THR_LOW,
    THR_MEDIUM,
    THR_HIGH
  } threshold_t;

  typedef enum logic [1:0] {
    CAUSE_PIN,
    CAUSE_WATCHDOG,
    CAUSE_BROWNOUT
  } reset_cause_t;

  typedef enum logic [1:0] {
    SEQ_RUN,
    SEQ_LV_HOLD,
    SEQ_DELAY
  } seq_t;

endpackage

// ===== hdl/dual_flop_sync.sv
// Two flip-flop synchroniser for levels entering the CPU clock domain.
// Assumes each bit is an independent level; no word coherence is implied.
module dual_flop_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t cur;
  sync_state_t next_cur;

  // First stage feeds only the second
  always_comb begin
    next_cur.meta = async_in;
    next_cur.stable = cur.meta;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cur <= {RESET_VALUE, RESET_VALUE};
    end else begin
      cur <= next_cur;
    end
  end

  assign sync_out = cur.stable;

endmodule

// ===== hdl/supply_integrity_monitor.sv
// Supply integrity monitor: low-voltage reset, supply warning interrupt
// and reset-cause flags behind one 8-bit control/status register.
// Assumes analog comparators, option bits and CPU mode signals from outside;
// rst_b is the power-on reset, chip resets are produced here.
//
// Function
// (RULE_01) Hold static reset while supply is low
// (RULE_02) Drive reset pin low during low-voltage reset
// (RULE_03) Detection optional, threshold low, medium or high
// (RULE_04) Warning logic works only with detection enabled
// (RULE_05) Bit 5 shows warning comparator, read-only
// (RULE_06) Interrupt on every warning bit change
// (RULE_07) Bit 6 is software interrupt enable
// (RULE_08) Pending cleared on entering service routine
// (RULE_09) Interrupt needs enable and CPU unmasked
// (RULE_10) No interrupt for crossing within reset delay
// (RULE_11) Enabling while below threshold raises interrupt
// (RULE_12) Wakes from wait, never from halt
// (RULE_13) Register frozen during halt
// (RULE_14) Bit 4 set by low-voltage reset, write-zero clears
// (RULE_15) Brownout flag survives pin and watchdog resets
// (RULE_16) Bit 0 watchdog flag, write-zero or brownout clears
// (RULE_17) Decode reset cause from both flags
// (RULE_18) Watchdog flag invalid without low-voltage detection
// (RULE_19) Software writes zero to unused bits
// (RULE_20) Synchronise comparators, detect toggles on synced value
module supply_integrity_monitor #(
  parameter int SHORT_DELAY = supply_integrity_pkg::SHORT_DELAY_CYC,
  parameter int LONG_DELAY = supply_integrity_pkg::LONG_DELAY_CYC
) (
  // Clock and power-on reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Option settings
  input wire logic lvd_option_enable,
  input wire supply_integrity_pkg::threshold_t lvd_option_threshold,
  input wire logic long_delay_option,
  // Analog comparator outputs, asynchronous
  input wire logic low_voltage_detector_below,
  input wire logic aux_voltage_warning_below,
  // Threshold and enable toward the comparators
  output supply_integrity_pkg::threshold_t low_voltage_detector_threshold,
  output logic aux_voltage_warning_enable,
  // Open-drain reset pin
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  // Reset sources and result
  input wire logic watchdog_reset,
  output logic chip_reset,
  output supply_integrity_pkg::reset_cause_t reset_cause,
  output logic reset_cause_valid,
  // Register port
  input wire logic [supply_integrity_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [supply_integrity_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [supply_integrity_pkg::DATA_W-1:0] reg_rdata,
  // CPU interrupt and mode interface
  input wire logic [1:0] cpu_int_level,
  input wire logic irq_ack,
  input wire logic halt_mode,
  output logic irq_req,
  output logic wait_wake
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    supply_integrity_pkg::seq_t seq;
    logic [supply_integrity_pkg::DELAY_CNT_W-1:0] delay_cnt;
    logic irq_enable;
    logic supply_warning_flag;
    logic brownout_reset_flag;
    logic watchdog_reset_flag;
    logic warn_pending;
    logic [supply_integrity_pkg::DATA_W-1:0] rdata;
  } monitor_state_t;

  monitor_state_t cur;
  monitor_state_t next_cur;

  logic rst_sync_b;
  logic lv_below_s;
  logic aux_below_s;
  logic pin_level_s;

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  function automatic logic [supply_integrity_pkg::DATA_W-1:0] csr_image(
    input monitor_state_t s
  );
    logic [supply_integrity_pkg::DATA_W-1:0] img;
    img = supply_integrity_pkg::CSR_RESET;
    img[supply_integrity_pkg::BIT_IRQ_EN] = s.irq_enable;
    img[supply_integrity_pkg::BIT_WARN] = s.supply_warning_flag;
    img[supply_integrity_pkg::BIT_BROWNOUT] = s.brownout_reset_flag;
    img[supply_integrity_pkg::BIT_WATCHDOG] = s.watchdog_reset_flag;
    return img;
  endfunction

  function automatic logic [supply_integrity_pkg::DELAY_CNT_W-1:0] delay_load(
    input logic use_long
  );
    logic [supply_integrity_pkg::DELAY_CNT_W-1:0] len;
    if (use_long) begin
      len = supply_integrity_pkg::DELAY_CNT_W'(LONG_DELAY - 1);
    end else begin
      len = supply_integrity_pkg::DELAY_CNT_W'(SHORT_DELAY - 1);
    end
    return len;
  endfunction

  // ------------------------------------------------------------
  // Reset release and input synchronisers
  // ------------------------------------------------------------
  dual_flop_sync #(
    .WIDTH(1),
    .RESET_VALUE(1'b0)
  ) u_rst_sync (
    .clk(ref_clk),
    .rst_b(rst_b),
    .async_in(1'b1),
    .sync_out(rst_sync_b)
  );

  // Supply assumed low and pin assumed released until sampled
  dual_flop_sync #(
    .WIDTH(3),
    .RESET_VALUE(3'h5)
  ) u_in_sync (
    .clk(ref_clk),
    .rst_b(rst_b),
    .async_in({low_voltage_detector_below, aux_voltage_warning_below, reset_pin_in}),
    .sync_out({lv_below_s, aux_below_s, pin_level_s})
  ); // RULE_20

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  logic lv_active;
  logic aux_live;
  logic csr_hit_wr;
  logic csr_hit_rd;
  logic warn_toggle;
  logic enable_arm;

  always_comb begin
    next_cur = cur;
    next_cur.rdata = '0;
    lv_active = lvd_option_enable && lv_below_s; // RULE_01 RULE_03
    aux_live = lvd_option_enable && aux_below_s; // RULE_04
    csr_hit_wr = reg_wr && (reg_addr == supply_integrity_pkg::CSR_OFFSET);
    csr_hit_rd = reg_rd && (reg_addr == supply_integrity_pkg::CSR_OFFSET);
    warn_toggle = 1'b0;
    enable_arm = 1'b0;

    // Read answer, unmapped reads give zero
    if (csr_hit_rd) begin
      next_cur.rdata = csr_image(cur); // RULE_19
    end

    if (lv_active) begin
      // Low-voltage reset: static, records brownout, clears watchdog
      next_cur.seq = supply_integrity_pkg::SEQ_LV_HOLD; // RULE_01
      next_cur.brownout_reset_flag = 1'b1; // RULE_14
      next_cur.watchdog_reset_flag = 1'b0; // RULE_16
      next_cur.irq_enable = 1'b0;
      next_cur.warn_pending = 1'b0;
      next_cur.supply_warning_flag = aux_live; // RULE_10
    end else if (watchdog_reset || !pin_level_s) begin
      // Pin or watchdog reset leaves the brownout flag alone
      next_cur.seq = supply_integrity_pkg::SEQ_DELAY; // RULE_15
      next_cur.delay_cnt = delay_load(long_delay_option);
      if (watchdog_reset) begin
        next_cur.watchdog_reset_flag = 1'b1; // RULE_16
      end
      next_cur.irq_enable = 1'b0;
      next_cur.warn_pending = 1'b0;
      next_cur.supply_warning_flag = aux_live; // RULE_10
    end else begin
      case (cur.seq)
        supply_integrity_pkg::SEQ_LV_HOLD: begin
          next_cur.seq = supply_integrity_pkg::SEQ_DELAY;
          next_cur.delay_cnt = delay_load(long_delay_option);
          next_cur.supply_warning_flag = aux_live; // RULE_10
        end
        supply_integrity_pkg::SEQ_DELAY: begin
          // Crossings during the delay are tracked silently
          next_cur.supply_warning_flag = aux_live; // RULE_10
          if (cur.delay_cnt == '0) begin
            next_cur.seq = supply_integrity_pkg::SEQ_RUN;
          end else begin
            next_cur.delay_cnt = cur.delay_cnt - 1'b1;
          end
        end
        supply_integrity_pkg::SEQ_RUN: begin
          if (!halt_mode) begin // RULE_13
            next_cur.supply_warning_flag = aux_live; // RULE_05
            warn_toggle = cur.supply_warning_flag != aux_live; // RULE_20
            if (irq_ack) begin
              next_cur.warn_pending = 1'b0; // RULE_08
            end
            if (csr_hit_wr) begin
              next_cur.irq_enable = reg_wdata[supply_integrity_pkg::BIT_IRQ_EN]; // RULE_07
              // Enabling while still below the warning level
              enable_arm = reg_wdata[supply_integrity_pkg::BIT_IRQ_EN] &&
                           !cur.irq_enable && cur.supply_warning_flag; // RULE_11
              if (!reg_wdata[supply_integrity_pkg::BIT_BROWNOUT]) begin
                next_cur.brownout_reset_flag = 1'b0; // RULE_14
              end
              if (!reg_wdata[supply_integrity_pkg::BIT_WATCHDOG]) begin
                next_cur.watchdog_reset_flag = 1'b0; // RULE_16
              end
            end
            // New event wins over a same-cycle acknowledge
            if ((cur.irq_enable && warn_toggle) || enable_arm) begin
              next_cur.warn_pending = 1'b1; // RULE_06 RULE_11
            end
          end
        end
        default: begin
          next_cur.seq = supply_integrity_pkg::SEQ_DELAY;
          next_cur.delay_cnt = delay_load(long_delay_option);
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cur.seq <= supply_integrity_pkg::SEQ_DELAY;
      cur.delay_cnt <= '0;
      cur.irq_enable <= supply_integrity_pkg::CSR_RESET[supply_integrity_pkg::BIT_IRQ_EN];
      cur.supply_warning_flag <= supply_integrity_pkg::CSR_RESET[supply_integrity_pkg::BIT_WARN];
      cur.brownout_reset_flag <=
        supply_integrity_pkg::CSR_RESET[supply_integrity_pkg::BIT_BROWNOUT];
      cur.watchdog_reset_flag <=
        supply_integrity_pkg::CSR_RESET[supply_integrity_pkg::BIT_WATCHDOG];
      cur.warn_pending <= 1'b0;
      cur.rdata <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign low_voltage_detector_threshold = lvd_option_threshold; // RULE_03
  assign aux_voltage_warning_enable = lvd_option_enable; // RULE_04

  // Open drain: only ever pulls low
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe = (cur.seq == supply_integrity_pkg::SEQ_LV_HOLD); // RULE_02
  assign chip_reset = (cur.seq != supply_integrity_pkg::SEQ_RUN); // RULE_01

  always_comb begin
    if (cur.brownout_reset_flag) begin
      reset_cause = supply_integrity_pkg::CAUSE_BROWNOUT; // RULE_17
    end else if (cur.watchdog_reset_flag) begin
      reset_cause = supply_integrity_pkg::CAUSE_WATCHDOG; // RULE_17
    end else begin
      reset_cause = supply_integrity_pkg::CAUSE_PIN; // RULE_17
    end
  end
  assign reset_cause_valid = lvd_option_enable; // RULE_18

  assign reg_rdata = cur.rdata;

  assign irq_req = cur.warn_pending && cur.irq_enable &&
                   (cpu_int_level != supply_integrity_pkg::LEVEL_MASKED) &&
                   (cur.seq == supply_integrity_pkg::SEQ_RUN); // RULE_09
  assign wait_wake = cur.warn_pending && cur.irq_enable && !halt_mode &&
                     (cur.seq == supply_integrity_pkg::SEQ_RUN); // RULE_12

endmodule

// ===== verification/supply_integrity_monitor_asserts.sv
// Port-level checker for the supply integrity monitor.
// Assumes it is bound to every monitor instance; one clock domain.
module supply_integrity_monitor_asserts (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Options and comparators
  input wire logic lvd_option_enable,
  input wire supply_integrity_pkg::threshold_t lvd_option_threshold,
  input wire logic low_voltage_detector_below,
  input wire logic aux_voltage_warning_below,
  input wire supply_integrity_pkg::threshold_t low_voltage_detector_threshold,
  input wire logic aux_voltage_warning_enable,
  // Reset outputs
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic chip_reset,
  input wire logic reset_cause_valid,
  // CPU side
  input wire logic reg_wr,
  input wire logic [1:0] cpu_int_level,
  input wire logic irq_ack,
  input wire logic halt_mode,
  input wire logic irq_req,
  input wire logic wait_wake
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence s_lv_low;
    (lvd_option_enable && low_voltage_detector_below) [*3];
  endsequence
  sequence s_aux_quiet;
    $stable(aux_voltage_warning_below) [*4];
  endsequence
  sequence s_halt_pair;
    (halt_mode && !chip_reset) ##1 (halt_mode && !chip_reset && $stable(cpu_int_level));
  endsequence

  property p_lv_hold;
    s_lv_low |=> chip_reset && reset_pin_oe;
  endproperty
  property p_pin_drive;
    reset_pin_oe |-> chip_reset && !reset_pin_out;
  endproperty
  property p_thr;
    low_voltage_detector_threshold == lvd_option_threshold;
  endproperty
  property p_warn_en;
    aux_voltage_warning_enable == lvd_option_enable;
  endproperty
  property p_irq_gate;
    irq_req |-> cpu_int_level != supply_integrity_pkg::LEVEL_MASKED && !chip_reset;
  endproperty
  property p_ack;
    s_aux_quiet ##0 (irq_ack && !reg_wr) |=> !irq_req;
  endproperty
  property p_wake;
    irq_req && !halt_mode |-> wait_wake;
  endproperty
  property p_no_halt_wake;
    wait_wake |-> !halt_mode && !chip_reset;
  endproperty
  property p_halt;
    s_halt_pair |-> $stable(irq_req);
  endproperty
  property p_cause_valid;
    reset_cause_valid == lvd_option_enable;
  endproperty

  a_lv_hold: assert property (p_lv_hold) else $error("no hold in low supply");
  a_pin_drive: assert property (p_pin_drive) else $error("bad pin drive");
  a_thr: assert property (p_thr) else $error("threshold mismatch");
  a_warn_en: assert property (p_warn_en) else $error("warning enable wrong");
  a_irq_gate: assert property (p_irq_gate) else $error("request while masked");
  a_ack: assert property (p_ack) else $error("pending not cleared");
  a_wake: assert property (p_wake) else $error("no wake");
  a_no_halt_wake: assert property (p_no_halt_wake) else $error("wake in halt");
  a_halt: assert property (p_halt) else $error("request moved in halt");
  a_cause_valid: assert property (p_cause_valid) else $error("cause valid wrong");
endmodule

bind supply_integrity_monitor supply_integrity_monitor_asserts u_chk (.ref_clk, .rst_b,
  .lvd_option_enable, .lvd_option_threshold, .low_voltage_detector_below,
  .aux_voltage_warning_below, .low_voltage_detector_threshold, .aux_voltage_warning_enable,
  .reset_pin_out, .reset_pin_oe, .chip_reset, .reset_cause_valid, .reg_wr, .cpu_int_level,
  .irq_ack, .halt_mode, .irq_req, .wait_wake);

// ===== verification/cpu_partner_model.sv
// Behavioural CPU core: takes the warning interrupt and drives the mask.
// Assumes the monitor's clock; irq_req is a level.
module cpu_partner_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Bench controls
  input wire logic masked,
  input wire logic [3:0] latency,
  output logic [7:0] taken,
  // Interrupt interface
  input wire logic irq_req,
  output logic [1:0] cpu_int_level,
  output logic irq_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] waited;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      waited <= 4'h0;
      taken <= 8'h00;
      irq_ack <= 1'b0;
      cpu_int_level <= 2'h3;
    end else begin
      cpu_int_level <= masked ? 2'h3 : 2'h2;
      irq_ack <= 1'b0;
      if (irq_ack) begin
        waited <= 4'h0;
      end else if (irq_req && waited >= latency) begin
        irq_ack <= 1'b1;
        taken <= taken + 8'h01;
      end else if (irq_req) begin
        waited <= waited + 4'h1;
      end
    end
  end
endmodule

// ===== verification/supply_integrity_monitor_tb_top.sv
// Self-checking bench for the supply integrity monitor.
// Assumes the CPU partner model and the bound checker are compiled first.
module supply_integrity_monitor_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NS = 4;
  logic ref_clk, rst_b, lvd_option_enable, long_delay_option, low_voltage_detector_below;
  logic aux_voltage_warning_below, ext_low, reset_pin_in, reset_pin_oe, watchdog_reset;
  logic chip_reset, reg_wr, reg_rd, irq_ack, halt_mode, irq_req, wait_wake, masked;
  logic [3:0] reg_addr, latency;
  logic [7:0] reg_wdata, reg_rdata, taken, n0;
  logic [1:0] cpu_int_level;
  supply_integrity_pkg::threshold_t lvd_option_threshold;
  supply_integrity_pkg::reset_cause_t reset_cause;
  int n_fail, tests_run, c;

  // Open-drain wire with pull-up
  assign reset_pin_in = ~(reset_pin_oe | ext_low);

  supply_integrity_monitor #(.SHORT_DELAY(NS), .LONG_DELAY(8)) u_dut (.ref_clk, .rst_b,
    .lvd_option_enable, .lvd_option_threshold, .long_delay_option, .low_voltage_detector_below,
    .aux_voltage_warning_below, .low_voltage_detector_threshold(), .aux_voltage_warning_enable(),
    .reset_pin_in, .reset_pin_out(), .reset_pin_oe, .watchdog_reset, .chip_reset, .reset_cause,
    .reset_cause_valid(), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_int_level,
    .irq_ack, .halt_mode, .irq_req, .wait_wake);
  cpu_partner_model u_cpu (.ref_clk, .rst_b, .masked, .latency, .taken, .irq_req,
    .cpu_int_level, .irq_ack);

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk8(reg_rdata, exp);
  endtask
  task automatic wait_run(output int cnt);
    for (cnt = 0; cnt < 99; cnt++) begin
      @(negedge ref_clk);
      if (chip_reset === 1'b0) break;
    end
    chk8({7'h0, chip_reset}, 8'h00);
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_power();
    tick(4);
    @(negedge ref_clk);
    chk8({6'h0, chip_reset, reset_pin_oe}, 8'h03);
    @(posedge ref_clk);
    low_voltage_detector_below <= 1'b0;
    aux_voltage_warning_below <= 1'b0;
    wait_run(c);
    tick(6);
    @(negedge ref_clk);
    chk8({6'h0, reset_cause}, 8'h02);
    // Enabling after the crossing must not raise anything
    wr(4'h0, 8'h50);
    tick(6);
    @(negedge ref_clk);
    chk8({7'h0, irq_req}, 8'h00);
    chk8(taken, 8'h00);
    wr(4'h0, 8'h10);
    rd(4'h0, 8'h10);
    $display("power_up done");
  endtask
  task automatic t_irq();
    n0 = taken;
    @(posedge ref_clk);
    latency <= 4'h5;
    aux_voltage_warning_below <= 1'b1;
    tick(8);
    @(negedge ref_clk);
    chk8({7'h0, irq_req}, 8'h00);
    wr(4'h0, 8'h50);
    tick(14);
    aux_voltage_warning_below <= 1'b0;
    tick(14);
    chk8(taken - n0, 8'h02);
    rd(4'h0, 8'h50);
    $display("warning_irq done");
  endtask
  task automatic t_halt();
    @(posedge ref_clk);
    latency <= 4'h0;
    masked <= 1'b1;
    aux_voltage_warning_below <= 1'b1;
    tick(8);
    @(negedge ref_clk);
    chk8({6'h0, irq_req, wait_wake}, 8'h01);
    @(posedge ref_clk);
    halt_mode <= 1'b1;
    aux_voltage_warning_below <= 1'b0;
    wr(4'h0, 8'h00);
    tick(4);
    @(negedge ref_clk);
    chk8({7'h0, wait_wake}, 8'h00);
    rd(4'h0, 8'h70);
    @(posedge ref_clk);
    masked <= 1'b0;
    halt_mode <= 1'b0;
    tick(12);
    @(negedge ref_clk);
    chk8({7'h0, irq_req}, 8'h00);
    $display("mask_halt done");
  endtask
  task automatic t_flags();
    @(posedge ref_clk);
    watchdog_reset <= 1'b1;
    @(posedge ref_clk);
    watchdog_reset <= 1'b0;
    wait_run(c);
    chk8(8'(c), 8'(NS));
    rd(4'h0, 8'h11);
    chk8({6'h0, reset_cause}, 8'h02);
    wr(4'h0, 8'h01);
    rd(4'h0, 8'h01);
    chk8({6'h0, reset_cause}, 8'h01);
    wr(4'h0, 8'h00);
    @(posedge ref_clk);
    ext_low <= 1'b1;
    tick(3);
    ext_low <= 1'b0;
    wait_run(c);
    chk8({6'h0, reset_cause}, 8'h00);
    @(posedge ref_clk);
    low_voltage_detector_below <= 1'b1;
    tick(5);
    @(negedge ref_clk);
    chk8({7'h0, reset_pin_oe}, 8'h01);
    @(posedge ref_clk);
    low_voltage_detector_below <= 1'b0;
    wait_run(c);
    wr(4'h0, 8'hff);
    rd(4'h0, 8'h50);
    rd(4'h3, 8'h00);
    $display("reset_flags done");
  endtask
  task automatic t_option_off();
    // Detection off: no reset from a low supply, warning stays quiet
    @(posedge ref_clk);
    lvd_option_enable <= 1'b0;
    low_voltage_detector_below <= 1'b1;
    aux_voltage_warning_below <= 1'b1;
    tick(8);
    @(negedge ref_clk);
    chk8({6'h0, chip_reset, irq_req}, 8'h00);
    rd(4'h0, 8'h50);
    $display("option_off done");
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict();
  end
  initial begin
    rst_b = 1'b0;
    {lvd_option_enable, long_delay_option, ext_low, watchdog_reset} = 4'h8;
    {reg_wr, reg_rd, halt_mode, masked} = 4'h0;
    low_voltage_detector_below = 1'b1;
    aux_voltage_warning_below = 1'b1;
    lvd_option_threshold = supply_integrity_pkg::THR_HIGH;
    {reg_addr, latency, reg_wdata} = 16'h0000;
    n_fail = 0;
    tests_run = 0;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_power();
    t_irq();
    t_halt();
    t_flags();
    t_option_off();
    print_verdict();
  end
endmodule
